// *** sscr_params.svh ***
// Constants for the serial configuration host controller.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SSCR_PARAMS_SVH
`define SSCR_PARAMS_SVH

// Software register offsets (word addresses on the local port)
`define SSCR_ADDR_CTRL      4'h0
`define SSCR_ADDR_STATUS    4'h1
`define SSCR_ADDR_CHANNEL   4'h2
`define SSCR_ADDR_MODREF    4'h3
`define SSCR_ADDR_PHASE     4'h4
`define SSCR_ADDR_FUNC      4'h5
`define SSCR_ADDR_PUMP      4'h6
`define SSCR_ADDR_PWRDN     4'h7
`define SSCR_ADDR_OUTSEL    4'h8
`define SSCR_ADDR_TEST      4'h9

// Register select codes in the low three bits of each word
`define SSCR_SEL_CHANNEL    3'h0
`define SSCR_SEL_MODREF     3'h1
`define SSCR_SEL_PHASE      3'h2
`define SSCR_SEL_FUNC       3'h3
`define SSCR_SEL_PUMP       3'h4
`define SSCR_SEL_PWRDN      3'h5
`define SSCR_SEL_OUTSEL     3'h6
`define SSCR_SEL_TEST       3'h7

// Word lengths in bits
`define SSCR_LEN_LONG       5'h18
`define SSCR_LEN_SHORT      5'h10

// Field positions
`define SSCR_CH_RSVD_BIT    23
`define SSCR_CH_INT_LSB     15
`define SSCR_CH_FRACTION_NUMERATOR_FIELD_LSB    3
`define SSCR_MR_RSVD_BIT    21
`define SSCR_MR_R_LSB       15
`define SSCR_MR_MOD_LSB     3
`define SSCR_PH_RSVD_BIT    15

// Legal field ranges
`define SSCR_INT_MIN        8'h1A
`define SSCR_R_MIN          4'h1
`define SSCR_MOD_MIN        12'h00D

// Serial clock half period, less one, in system clocks
`define SSCR_HALF_DEFAULT   4'h4

// Status register bits
`define SSCR_ST_BUSY        0
`define SSCR_ST_REJECT      1
`define SSCR_ST_CHDONE      2

`endif

// *** sscr_pkg.sv ***
// Types for the serial configuration host controller.
// Assumes sscr_params.svh is visible to every user.
package sscr_pkg;

    // Shift engine states, Gray coded along the path
    typedef enum logic [1:0] {
        SSCR_IDLE  = 2'b00,
        SSCR_LOW   = 2'b01,
        SSCR_HIGH  = 2'b11,
        SSCR_LATCH = 2'b10
    } sscr_state_e;

    // Three-wire link pins
    typedef struct packed {
        logic sclk;
        logic data;
        logic latch_strobe;
    } sscr_link_s;

    // Local register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [23:0] wdata;
    } sscr_req_s;

endpackage : sscr_pkg

// *** sscr_host.sv ***
// Host controller that programs the synthesizer's eight serial registers.
// Assumes a single 100 MHz clock and a synchronous local register port.
`timescale 1ns/1ns
`default_nettype none
`include "sscr_params.svh"

// How it works
// - Shift 24-, 16- or 8-bit word MSB first, rising edge.
// - Channel word uses select code 000.
// - Modulus word uses select code 001.
// - After init, channel change needs one write.
// - Channel word top bit forced zero.
// - Integer field kept within 26..255.
// - Fraction kept below the modulus.
// - Modulus word reserved bit forced zero.
// - Reference divider kept within 1..15.
// - Modulus kept within 13..4095.
// - Phase change followed by channel rewrite.
// - Channel writes spaced by modulus cycles; the code accepts one whenever idle and leaves spacing to software.
// - Twin devices written in one cycle; the code drives a single device link only.
// - Phase word top bit forced zero.
module sscr_host
    import sscr_pkg::*;
#(
    parameter logic [3:0] HALF_PERIOD = `SSCR_HALF_DEFAULT
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    output logic      [23:0] rdata_o,
    output logic             sclk_o,
    output logic             sdata_o,
    output logic             latch_strobe_o
);

    // Elaboration check: refuses a zero half period, which would run the link clock at half the system clock
    if (HALF_PERIOD == 4'h0) begin : g_half_check
        $error("HALF_PERIOD must be at least one");
    end

    // Whole module state
    typedef struct packed {
        sscr_state_e state;
        logic [23:0] shreg;
        logic [4:0]  bits_left;
        logic [3:0]  tick;
        logic        auto_chan;
        logic [2:0]  cur_sel;
        logic        reject;
        logic        ch_done;
        logic [23:0] channel;
        logic [23:0] modref;
        logic [15:0] phase;
        logic [15:0] func;
        logic [23:0] pump;
        logic [7:0]  pwrdn;
        logic [15:0] outsel;
        logic [15:0] test;
        logic [23:0] rdata;
        sscr_link_s  link;
    } sscr_state_s;

    sscr_state_s st_r;
    sscr_state_s st_nxt;
    sscr_req_s   req;

    logic [7:0]  int_f;
    logic [11:0] fraction_numerator_field_f;
    logic [11:0] mod_f;
    logic [3:0]  r_f;

    assign req   = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
    assign int_f = st_r.channel[`SSCR_CH_INT_LSB +: 8];
    assign fraction_numerator_field_f = st_r.channel[`SSCR_CH_FRACTION_NUMERATOR_FIELD_LSB +: 12];
    assign mod_f = st_r.modref[`SSCR_MR_MOD_LSB +: 12];
    assign r_f   = st_r.modref[`SSCR_MR_R_LSB +: 4];

    // Build a word, left justify short words so MSB leaves first
    function automatic logic [23:0] sscr_frame(input logic [23:0] w, input logic [2:0] sel);
        logic [23:0] f;
        f = {w[23:3], sel};
        if (sel == `SSCR_SEL_CHANNEL || sel == `SSCR_SEL_MODREF || sel == `SSCR_SEL_PUMP) begin
            sscr_frame = f;
        end else if (sel == `SSCR_SEL_PWRDN) begin
            sscr_frame = {f[7:0], 16'h0000};
        end else begin
            sscr_frame = {f[15:0], 8'h00};
        end
    endfunction : sscr_frame

    // Word length per select code
    function automatic logic [4:0] sscr_len(input logic [2:0] sel);
        if (sel == `SSCR_SEL_CHANNEL || sel == `SSCR_SEL_MODREF || sel == `SSCR_SEL_PUMP) begin
            sscr_len = `SSCR_LEN_LONG;
        end else if (sel == `SSCR_SEL_PWRDN) begin
            sscr_len = 5'h08;
        end else begin
            sscr_len = `SSCR_LEN_SHORT;
        end
    endfunction : sscr_len

    // Next state logic
    always_comb begin
        logic [23:0] w;
        logic [2:0]  sel;
        logic        go;
        logic        ok;
        w   = 24'h000000;
        sel = 3'h0;
        go  = 1'b0;
        ok  = 1'b1;
        st_nxt = st_r;
        st_nxt.rdata = 24'h000000;
        // Register port reads
        if (req.rd) begin
            unique case (req.addr)
                `SSCR_ADDR_CTRL:    st_nxt.rdata = {23'h000000, st_r.auto_chan};
                `SSCR_ADDR_STATUS:  st_nxt.rdata = {21'h000000, st_r.ch_done, st_r.reject,
                                                    st_r.state != SSCR_IDLE};
                `SSCR_ADDR_CHANNEL: st_nxt.rdata = st_r.channel;
                `SSCR_ADDR_MODREF:  st_nxt.rdata = st_r.modref;
                `SSCR_ADDR_PHASE:   st_nxt.rdata = {8'h00, st_r.phase};
                `SSCR_ADDR_FUNC:    st_nxt.rdata = {8'h00, st_r.func};
                `SSCR_ADDR_PUMP:    st_nxt.rdata = st_r.pump;
                `SSCR_ADDR_PWRDN:   st_nxt.rdata = {16'h0000, st_r.pwrdn};
                `SSCR_ADDR_OUTSEL:  st_nxt.rdata = {8'h00, st_r.outsel};
                `SSCR_ADDR_TEST:    st_nxt.rdata = {8'h00, st_r.test};
                default:            st_nxt.rdata = 24'h000000;
            endcase
        end
        // Register port writes; data words start a transfer when idle
        if (req.wr) begin
            w = req.wdata;
            unique case (req.addr)
                `SSCR_ADDR_CTRL: begin
                    st_nxt.auto_chan = w[0];
                    if (w[1]) begin
                        st_nxt.reject  = 1'b0;
                        st_nxt.ch_done = 1'b0;
                    end
                end
                `SSCR_ADDR_CHANNEL: begin
                    // One channel word alone retunes once set up
                    sel = `SSCR_SEL_CHANNEL;
                    w[`SSCR_CH_RSVD_BIT] = 1'b0;
                    ok = (w[`SSCR_CH_INT_LSB +: 8] >= `SSCR_INT_MIN)
                       && (w[`SSCR_CH_FRACTION_NUMERATOR_FIELD_LSB +: 12] < mod_f);
                    go = 1'b1;
                end
                `SSCR_ADDR_MODREF: begin
                    sel = `SSCR_SEL_MODREF;
                    w[`SSCR_MR_RSVD_BIT] = 1'b0;
                    ok = (w[`SSCR_MR_R_LSB +: 4] >= `SSCR_R_MIN)
                       && (w[`SSCR_MR_MOD_LSB +: 12] >= `SSCR_MOD_MIN);
                    go = 1'b1;
                end
                `SSCR_ADDR_PHASE: begin
                    sel = `SSCR_SEL_PHASE;
                    w[`SSCR_PH_RSVD_BIT] = 1'b0;
                    ok = (w[`SSCR_CH_FRACTION_NUMERATOR_FIELD_LSB +: 12] <= mod_f);
                    go = 1'b1;
                end
                `SSCR_ADDR_FUNC:   begin sel = `SSCR_SEL_FUNC;   go = 1'b1; end
                `SSCR_ADDR_PUMP:   begin sel = `SSCR_SEL_PUMP;   go = 1'b1; end
                `SSCR_ADDR_PWRDN:  begin sel = `SSCR_SEL_PWRDN;  go = 1'b1; end
                `SSCR_ADDR_OUTSEL: begin sel = `SSCR_SEL_OUTSEL; go = 1'b1; end
                `SSCR_ADDR_TEST:   begin sel = `SSCR_SEL_TEST;   go = 1'b1; end
                default: go = 1'b0;
            endcase
        end
        // Busy or illegal words are refused and flagged
        if (go && (st_r.state != SSCR_IDLE || !ok)) begin
            st_nxt.reject = 1'b1;
        end else if (go) begin
            unique case (sel)
                `SSCR_SEL_CHANNEL: st_nxt.channel = w;
                `SSCR_SEL_MODREF:  st_nxt.modref  = w;
                `SSCR_SEL_PHASE:   st_nxt.phase   = w[15:0];
                `SSCR_SEL_FUNC:    st_nxt.func    = w[15:0];
                `SSCR_SEL_PUMP:    st_nxt.pump    = w;
                `SSCR_SEL_PWRDN:   st_nxt.pwrdn   = w[7:0];
                `SSCR_SEL_OUTSEL:  st_nxt.outsel  = w[15:0];
                `SSCR_SEL_TEST:    st_nxt.test    = w[15:0];
            endcase
            st_nxt.shreg     = sscr_frame(w, sel);
            st_nxt.bits_left = sscr_len(sel);
            st_nxt.tick      = HALF_PERIOD;
            st_nxt.cur_sel   = sel;
            st_nxt.state     = SSCR_LOW;
            st_nxt.ch_done   = (sel == `SSCR_SEL_CHANNEL) ? 1'b0 : st_r.ch_done;
        end
        // Serial engine
        if (st_r.state != SSCR_IDLE && st_r.tick != 4'h0) begin
            st_nxt.tick = st_r.tick - 4'h1;
        end else begin
            unique case (st_r.state)
                SSCR_IDLE: begin
                    st_nxt.link.sclk = 1'b0;
                end
                SSCR_LOW: begin
                    // Data set up while clock low, then rise
                    st_nxt.link.data = st_r.shreg[23];
                    st_nxt.link.sclk = 1'b0;
                    st_nxt.tick  = HALF_PERIOD;
                    st_nxt.state = SSCR_HIGH;
                end
                SSCR_HIGH: begin
                    st_nxt.link.sclk = 1'b1;
                    st_nxt.shreg     = {st_r.shreg[22:0], 1'b0};
                    st_nxt.bits_left = st_r.bits_left - 5'h01;
                    st_nxt.tick      = HALF_PERIOD;
                    st_nxt.state     = (st_r.bits_left == 5'h01) ? SSCR_LATCH : SSCR_LOW;
                end
                SSCR_LATCH: begin
                    // Clock low and latch strobe rise in the same cycle, then strobe pulse ends
                    st_nxt.link.sclk = 1'b0;
                    if (!st_r.link.latch_strobe) begin
                        st_nxt.link.latch_strobe = 1'b1;
                        st_nxt.tick = HALF_PERIOD;
                    end else begin
                        st_nxt.link.latch_strobe = 1'b0;
                        st_nxt.state = SSCR_IDLE;
                        // Channel latch commits shadowed words in the device
                        // Fixed write-to-strobe latency lets software space or pair latches
                        if (st_r.cur_sel == `SSCR_SEL_CHANNEL) begin
                            st_nxt.ch_done = 1'b1;
                        end
                    end
                end
            endcase
        end
        // Optional automatic channel rewrite after a modulus or phase word
        if (st_r.auto_chan && st_r.state == SSCR_LATCH && st_r.link.latch_strobe
            && st_r.tick == 4'h0 && !go
            && (st_r.cur_sel == `SSCR_SEL_MODREF || st_r.cur_sel == `SSCR_SEL_PHASE)) begin
            st_nxt.shreg     = sscr_frame(st_r.channel, `SSCR_SEL_CHANNEL);
            st_nxt.bits_left = `SSCR_LEN_LONG;
            st_nxt.tick      = HALF_PERIOD;
            st_nxt.cur_sel   = `SSCR_SEL_CHANNEL;
            st_nxt.state     = SSCR_LOW;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o        = st_r.rdata;
    assign sclk_o         = st_r.link.sclk;
    assign sdata_o        = st_r.link.data;
    assign latch_strobe_o = st_r.link.latch_strobe;

    // Last cycle of a latch strobe pulse
    sequence s_latch_end;
        st_r.state == SSCR_LATCH && st_r.link.latch_strobe && st_r.tick == 4'h0;
    endsequence

    // Engine leaves idle for a new frame
    sequence s_frame_start;
        st_r.state == SSCR_IDLE ##1 st_r.state == SSCR_LOW;
    endsequence

    // Link protocol checks
    a_strobe_in_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        st_r.link.latch_strobe |-> st_r.state == SSCR_LATCH && !st_r.link.sclk)
        else $error("latch strobe outside latch phase");
    a_data_at_rise: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(st_r.link.sclk) |-> $stable(st_r.link.data))
        else $error("data moved at serial clock rise");
    a_frame_bit_count: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(st_r.link.latch_strobe) |-> st_r.bits_left == 5'h00)
        else $error("strobe before all bits shifted");
    a_idle_link_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_frame_start |-> !st_r.link.sclk && !st_r.link.latch_strobe)
        else $error("link not quiet at frame start");

    // Local port and commit checks
    a_int_range_refused: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_i && addr_i == `SSCR_ADDR_CHANNEL && wdata_i[`SSCR_CH_INT_LSB +: 8] < `SSCR_INT_MIN
        |=> st_r.reject)
        else $error("low integer field not refused");
    a_rsvd_bits_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !st_r.channel[`SSCR_CH_RSVD_BIT] && !st_r.modref[`SSCR_MR_RSVD_BIT]
        && !st_r.phase[`SSCR_PH_RSVD_BIT])
        else $error("reserved bit stored as one");
    a_channel_done: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_latch_end ##0 st_r.cur_sel == `SSCR_SEL_CHANNEL |=> st_r.ch_done)
        else $error("channel latch not flagged");
    a_auto_rewrite: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_latch_end ##0 (st_r.auto_chan && st_r.cur_sel == `SSCR_SEL_PHASE && !wr_i)
        |=> st_r.state == SSCR_LOW && st_r.cur_sel == `SSCR_SEL_CHANNEL)
        else $error("channel rewrite missing after phase");

endmodule : sscr_host

`default_nettype wire

// *** sscr_dev_model.sv ***
// Behavioural model of the synthesizer's serial register bank.
// Assumes the host drives clock, data and strobe; no reset needed.
`timescale 1ns/1ns
`default_nettype none
module sscr_dev_model (
    input  wire logic sclk_i,
    input  wire logic data_i,
    input  wire logic latch_strobe_i
);
    logic [23:0] sh_r;
    logic [23:0] word_r;
    logic [4:0]  nbit_r = 5'h00;
    logic [4:0]  len_r;
    int          frames = 0;
    logic [23:0] regs_r [8];
    logic [8:0]  timer_r [4];
    logic [11:0] mod_act_r;
    logic [11:0] ph_act_r;
    logic        fast_lock_r = 1'b0;

    // Shift in MSB first on each clock rise
    always @(posedge sclk_i) begin
        sh_r   = {sh_r[22:0], data_i};
        nbit_r = nbit_r + 5'h01;
    end

    // Strobe rise moves the word to the register the low bits name
    always @(posedge latch_strobe_i) begin
        word_r = sh_r;
        len_r  = nbit_r;
        nbit_r = 5'h00;
        frames++;
        regs_r[sh_r[2:0]] = sh_r;
        if (sh_r[2:0] == 3'h4)
            timer_r[sh_r[4:3]] = sh_r[13:5];
        // Channel write commits shadowed settings and starts fast lock
        if (sh_r[2:0] == 3'h0) begin
            mod_act_r   = regs_r[1][14:3];
            ph_act_r    = regs_r[2][14:3];
            fast_lock_r = 1'b1;
        end
    end
endmodule : sscr_dev_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the serial configuration host controller.
// Assumes the device model mirrors every word latched on the link.
`timescale 1ns/1ns
`default_nettype none
`include "sscr_params.svh"
module tb_top import sscr_pkg::*;;
    logic        clk_sys_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [3:0]  addr_i    = 4'h0;
    logic [23:0] wdata_i   = 24'h000000;
    logic [23:0] rdata_o;
    logic [23:0] rd_v;
    logic        sclk_o;
    logic        sdata_o;
    logic        latch_strobe_o;
    int          n_fail    = 0;
    int          checks_done = 0;

    // System clock, 10 ns period
    always #5 clk_sys_i = ~clk_sys_i;

    sscr_host #(.HALF_PERIOD(4'h2)) dut_u (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sclk_o(sclk_o),
        .sdata_o(sdata_o), .latch_strobe_o(latch_strobe_o));
    sscr_dev_model m_u (.sclk_i(sclk_o), .data_i(sdata_o), .latch_strobe_i(latch_strobe_o));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_sys_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1 rd_v = rdata_o;
    endtask : bus_rd

    // Poll status until the link is idle, bounded
    task automatic send(input logic [3:0] a, input logic [23:0] d);
        int k;
        k = 0;
        bus_wr(a, d);
        repeat (3) @(posedge clk_sys_i);
        bus_rd(`SSCR_ADDR_STATUS);
        while (rd_v[`SSCR_ST_BUSY] !== 1'b0 && k < 400) begin
            bus_rd(`SSCR_ADDR_STATUS);
            k++;
        end
        if (k >= 400) begin
            n_fail++;
            $display("[ERR] %0t busy never cleared", $time);
        end
    endtask : send

    // Modulus word: reserved bit cleared, select 001, held in shadow
    task automatic t_modref;
        send(`SSCR_ADDR_MODREF, 24'hA2FFF8);
        chk(m_u.word_r, 24'h82FFF9, "modref word");
        chk({19'h0, m_u.len_r}, 24'h000018, "modref length");
        chk({23'h0, rd_v[`SSCR_ST_CHDONE]}, 24'h000000, "no commit on modref");
        $display("test modref done");
    endtask : t_modref

    // Channel word: top bit cleared, select 000, settings committed
    task automatic t_channel;
        send(`SSCR_ADDR_CHANNEL, 24'hC0ABC8);
        chk(m_u.word_r, 24'h40ABC8, "channel word");
        chk({12'h0, m_u.mod_act_r}, 24'h000FFF, "modulus commit");
        chk({23'h0, rd_v[`SSCR_ST_CHDONE]}, 24'h000001, "channel done flag");
        $display("test channel done");
    endtask : t_channel

    // Phase word waits for the next channel write
    task automatic t_phase;
        send(`SSCR_ADDR_PHASE, 24'h000010);
        send(`SSCR_ADDR_CHANNEL, 24'h40ABC8);
        chk({12'h0, m_u.ph_act_r}, 24'h000002, "phase first commit");
        send(`SSCR_ADDR_PHASE, 24'h00FFF8);
        chk({8'h0, m_u.word_r[15:0]}, 24'h007FFA, "phase word");
        chk({19'h0, m_u.len_r}, 24'h000010, "phase length");
        chk({12'h0, m_u.ph_act_r}, 24'h000002, "phase early");
        send(`SSCR_ADDR_CHANNEL, 24'h40ABC8);
        chk({12'h0, m_u.ph_act_r}, 24'h000FFF, "phase commit");
        $display("test phase done");
    endtask : t_phase

    // Remaining registers each carry their own select code
    task automatic t_select;
        for (int i = 5; i <= 9; i++) begin
            send(i[3:0], 24'h000000);
            chk({21'h0, m_u.word_r[2:0]}, 24'(i - 2), "select code");
        end
        send(`SSCR_ADDR_PUMP, 24'h000394);
        chk({15'h0, m_u.timer_r[2]}, 24'h00001C, "pump timer");
        $display("test select done");
    endtask : t_select

    // Automatic channel rewrite follows a phase word
    task automatic t_auto;
        int f0;
        bus_wr(`SSCR_ADDR_CTRL, 24'h000003);
        f0 = m_u.frames;
        send(`SSCR_ADDR_PHASE, 24'h000020);
        chk(24'(m_u.frames - f0), 24'h000002, "auto frame count");
        chk(m_u.word_r, 24'h40ABC8, "auto channel word");
        chk({12'h0, m_u.ph_act_r}, 24'h000004, "auto phase commit");
        chk({23'h0, rd_v[`SSCR_ST_CHDONE]}, 24'h000001, "auto done flag");
        bus_wr(`SSCR_ADDR_CTRL, 24'h000000);
        $display("test auto done");
    endtask : t_auto

    // Out-of-range fields are refused and never reach the link
    task automatic t_reject;
        logic [3:0]  ra [3];
        logic [23:0] rd [3];
        int          f0;
        ra = '{`SSCR_ADDR_CHANNEL, `SSCR_ADDR_MODREF, `SSCR_ADDR_MODREF};
        rd = '{24'h050000, 24'h000068, 24'h008060};
        for (int i = 0; i < 3; i++) begin
            bus_wr(`SSCR_ADDR_CTRL, 24'h000002);
            f0 = m_u.frames;
            send(ra[i], rd[i]);
            chk(24'(m_u.frames), 24'(f0), "refused frame sent");
            chk({23'h0, rd_v[`SSCR_ST_REJECT]}, 24'h000001, "reject flag");
        end
        $display("test reject done");
    endtask : t_reject

    task automatic finish_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        t_modref();
        t_channel();
        t_phase();
        t_select();
        t_auto();
        t_reject();
        finish_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        #500000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
